// ===== include/mir_pkg.sv
// shared constants and carrier types of the microcontroller interrupt router
package mir_pkg;
    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int RING_GROUPS = 8;
    localparam int OTHER_GROUPS = 5;
    localparam int VEC_GROUPS = 16;
    localparam int GROUP_VECS = 16;
    localparam int VEC_W = VEC_GROUPS * GROUP_VECS;
    localparam int FIELD_W = 4;
    localparam int ENGINES = 16;
    localparam int CSQ_PORTS = 4;
    localparam int HOST_VEC_W = 16;
    localparam int SP_W = 6;
    localparam int WORD_LSB = 2;
    localparam int RING_IDX_MSB = 4;
    localparam int CSQ_IDX_MSB = 3;
    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [15:0] MICRO_TO_HOST_TRIG = 16'hC4B8;
    localparam logic [15:0] HOST_TO_MICRO_TRIG = 16'hC4C8;
    localparam logic [15:0] HOST_MSG_DATA = 16'hC590;
    localparam logic [15:0] RING_GROUP_PRIORITY_MAP = 16'hC500;
    localparam logic [15:0] OTHER_SOURCE_PRIORITY_MAP = 16'hC504;
    localparam logic [15:0] RING_NOTIFY_CONTROL = 16'hC508;
    localparam logic [15:0] SOURCE_PENDING = 16'hC50C;
    localparam logic [15:0] ENGINE_PENDING = 16'hC510;
    localparam logic [15:0] ENGINE_ROUTE = 16'hC514;
    localparam logic [15:0] CSQ_STATUS = 16'hC518;
    localparam logic [15:0] RING_STATUS_BASE = 16'hC520;
    localparam logic [15:0] RING_SPAN_MASK = 16'h001F;
    localparam logic [15:0] CSQ_PORT_BASE = 16'hC540;
    localparam logic [15:0] CSQ_SPAN_MASK = 16'h000F;
    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int ROUTE_BIT = 8;
    localparam int SP_SEM = 0;
    localparam int SP_IOMMU = 1;
    localparam int SP_DMA = 2;
    localparam int SP_TIMER = 3;
    localparam int SP_FLR = 4;
    localparam int SP_HOST = 5;
    localparam int OG_SEM = 0;
    localparam int OG_ENG = 1;
    localparam int OG_IOMMU = 2;
    localparam int OG_MISC = 3;
    localparam int OG_HOST = 4;
    localparam int HV_RING = 0;
    localparam int HV_ENGINE = 1;
    localparam logic [15:0] FW_OWNED_MASK = 16'hFF00;
    localparam logic [3:0] FIELD_OFF = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [63:0] data;
    } mir_csq_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } mir_wreq_t;
endpackage

// ===== logic/mir_router.sv
// interrupt router: priority mapping, ring routing, host notify, status ports
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module mir_router (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [15:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [15:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [7:0] RING_RUNG_SET,
    input wire logic [7:0][31:0] RING_GROUP_DATA,
    input wire logic SEMAPHORE_EVENT,
    input wire logic [15:0] ENGINE_EVENT,
    input wire logic IOMMU_EVENT,
    input wire logic COPY_DONE_EVENT,
    input wire logic TIMER_EVENT,
    input wire logic FLR_EVENT,
    input wire mir_pkg::mir_csq_t [3:0] CSQ_ENTRY,
    output logic [3:0] CSQ_POP,
    input wire logic [15:0] HOST_VEC_ACK,
    output logic [255:0] LIC_VECTOR,
    output logic [3:0] LIC_TOP_GROUP,
    output logic LIC_TOP_VALID,
    output logic [15:0] HOST_INTR_VEC
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0] ring_map;
    logic [31:0] other_map;
    logic [7:0] rung;
    logic ring_route;
    logic [15:0] engine_route;
    logic [15:0] engine_pending;
    logic [5:0] src_pending;
    logic [31:0] msg_data;
    logic [3:0] csq_half;
    mir_pkg::mir_wreq_t wreq;
    logic aw_held;
    logic w_held;
    logic wr_go;
    logic wr_err;
    logic rd_go;
    logic rd_err;
    logic [31:0] rd_val;
    logic [7:0] ring_clr;
    logic [3:0] csq_sel;
    logic [255:0] next_vector;
    logic [3:0] next_top;
    logic next_top_valid;
    logic [15:0] eng_core;
    logic [15:0] eng_host;
    logic fw_trig;
    logic host_trig;

    // ****************************************************************
    // write channel capture
    // ****************************************************************
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign wr_go = aw_held && w_held && !S_AXI_BVALID;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wreq <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= mir_pkg::RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held <= 1'b1;
                wreq.addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held <= 1'b1;
                wreq.data <= S_AXI_WDATA;
                wreq.strb <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_err ? mir_pkg::RESP_SLVERR : mir_pkg::RESP_OKAY;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input mir_pkg::mir_wreq_t r);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (r.strb[b])
            begin
                res[b*8 +: 8] = r.data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb
    begin
        fw_trig = 1'b0;
        host_trig = 1'b0;
        wr_err = 1'b0;
        case (wreq.addr)
            mir_pkg::MICRO_TO_HOST_TRIG: fw_trig = wr_go;
            mir_pkg::HOST_TO_MICRO_TRIG: host_trig = wr_go;
            mir_pkg::RING_GROUP_PRIORITY_MAP,
            mir_pkg::OTHER_SOURCE_PRIORITY_MAP,
            mir_pkg::RING_NOTIFY_CONTROL,
            mir_pkg::SOURCE_PENDING,
            mir_pkg::ENGINE_PENDING,
            mir_pkg::ENGINE_ROUTE: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ring_map <= '0;
            other_map <= '0;
            engine_route <= '0;
            ring_route <= 1'b0;
            msg_data <= '0;
        end
        else if (wr_go)
        begin
            if (wreq.addr == mir_pkg::RING_GROUP_PRIORITY_MAP)
                ring_map <= merge(ring_map, wreq);
            if (wreq.addr == mir_pkg::OTHER_SOURCE_PRIORITY_MAP)
                other_map <= merge(other_map, wreq) & {{(32 - 20){1'b0}}, {20{1'b1}}};
            if (wreq.addr == mir_pkg::ENGINE_ROUTE)
                engine_route <= 16'(merge({16'h0000, engine_route}, wreq));
            if (wreq.addr == mir_pkg::RING_NOTIFY_CONTROL && wreq.strb[1])
                ring_route <= wreq.data[mir_pkg::ROUTE_BIT];
            if (host_trig)
                msg_data <= merge(msg_data, wreq);
        end
    end

    // ****************************************************************
    // rung bits
    // ****************************************************************
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            rung <= '0;
        end
        else
        begin
            // set from message, cleared by status read, set wins
            rung <= (rung & ~ring_clr) | RING_RUNG_SET;
        end
    end

    // ****************************************************************
    // sticky pending sources
    // ****************************************************************
    // engine routing split
    assign eng_core = ENGINE_EVENT & engine_route;
    assign eng_host = ENGINE_EVENT & ~engine_route;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            src_pending <= '0;
            engine_pending <= '0;
        end
        else
        begin
            logic [5:0] sp_clr;
            logic [15:0] ep_clr;
            sp_clr = '0;
            ep_clr = '0;
            if (wr_go && wreq.addr == mir_pkg::SOURCE_PENDING && wreq.strb[0])
                sp_clr = wreq.data[5:0];
            if (wr_go && wreq.addr == mir_pkg::ENGINE_PENDING)
                ep_clr = 16'(merge(32'h0000_0000, wreq));
            src_pending <= (src_pending & ~sp_clr) | {host_trig, FLR_EVENT, TIMER_EVENT,
                COPY_DONE_EVENT, IOMMU_EVENT, SEMAPHORE_EVENT};
            engine_pending <= (engine_pending & ~ep_clr) | eng_core;
        end
    end

    // ****************************************************************
    // host vector
    // ****************************************************************
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            HOST_INTR_VEC <= '0;
        end
        else
        begin
            logic [15:0] hw_set;
            logic [15:0] fw_set;
            hw_set = '0;
            fw_set = '0;
            // rings go to host unless routed to core
            hw_set[mir_pkg::HV_RING] = |RING_RUNG_SET && !ring_route;
            hw_set[mir_pkg::HV_ENGINE] = |eng_host;
            // firmware sets only its own bits
            if (fw_trig)
                fw_set = wreq.data[15:0] & mir_pkg::FW_OWNED_MASK;
            HOST_INTR_VEC <= (HOST_INTR_VEC & ~HOST_VEC_ACK) | hw_set | fw_set;
        end
    end

    // ****************************************************************
    // vector mapping and priority
    // ****************************************************************
    always_comb
    begin
        logic [15:0] local_vec;
        logic [3:0] fld;
        local_vec = '0;
        fld = '0;
        next_vector = '0;
        next_top = '0;
        next_top_valid = 1'b0;
        // each group whose field is not FIELD_OFF ORed into its slice
        for (int g = 0; g < mir_pkg::RING_GROUPS; g++)
        begin
            fld = ring_map[g*mir_pkg::FIELD_W +: mir_pkg::FIELD_W];
            local_vec = '0;
            local_vec[g] = rung[g] && ring_route;
            if (fld != mir_pkg::FIELD_OFF)
                next_vector[fld*mir_pkg::GROUP_VECS +: mir_pkg::GROUP_VECS] =
                    next_vector[fld*mir_pkg::GROUP_VECS +: mir_pkg::GROUP_VECS] | local_vec;
        end
        for (int g = 0; g < mir_pkg::OTHER_GROUPS; g++)
        begin
            fld = other_map[g*mir_pkg::FIELD_W +: mir_pkg::FIELD_W];
            local_vec = '0;
            case (g)
                mir_pkg::OG_SEM: local_vec[0] = src_pending[mir_pkg::SP_SEM];
                mir_pkg::OG_ENG: local_vec = engine_pending;
                mir_pkg::OG_IOMMU: local_vec[0] = src_pending[mir_pkg::SP_IOMMU];
                mir_pkg::OG_MISC: local_vec[2:0] = src_pending[mir_pkg::SP_FLR:mir_pkg::SP_DMA];
                default: local_vec[0] = src_pending[mir_pkg::SP_HOST];
            endcase
            if (fld != mir_pkg::FIELD_OFF)
                next_vector[fld*mir_pkg::GROUP_VECS +: mir_pkg::GROUP_VECS] =
                    next_vector[fld*mir_pkg::GROUP_VECS +: mir_pkg::GROUP_VECS] | local_vec;
        end
        for (int s = 0; s < mir_pkg::VEC_GROUPS; s++)
        begin
            if (|next_vector[s*mir_pkg::GROUP_VECS +: mir_pkg::GROUP_VECS])
            begin
                next_top = 4'(s);
                next_top_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            LIC_VECTOR <= '0;
            LIC_TOP_GROUP <= '0;
            LIC_TOP_VALID <= 1'b0;
        end
        else
        begin
            LIC_VECTOR <= next_vector;
            LIC_TOP_GROUP <= next_top;
            LIC_TOP_VALID <= next_top_valid;
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

    always_comb
    begin
        logic [2:0] ri;
        logic [1:0] ci;
        ri = S_AXI_ARADDR[mir_pkg::RING_IDX_MSB:mir_pkg::WORD_LSB];
        ci = S_AXI_ARADDR[mir_pkg::CSQ_IDX_MSB:mir_pkg::WORD_LSB];
        rd_val = '0;
        rd_err = 1'b0;
        ring_clr = '0;
        csq_sel = '0;
        case (S_AXI_ARADDR)
            mir_pkg::HOST_MSG_DATA: rd_val = msg_data;
            mir_pkg::RING_GROUP_PRIORITY_MAP: rd_val = ring_map;
            mir_pkg::OTHER_SOURCE_PRIORITY_MAP: rd_val = other_map;
            mir_pkg::RING_NOTIFY_CONTROL: rd_val = {23'h000000, ring_route, rung};
            mir_pkg::SOURCE_PENDING: rd_val = {26'h0000000, src_pending};
            mir_pkg::ENGINE_PENDING: rd_val = {16'h0000, engine_pending};
            mir_pkg::ENGINE_ROUTE: rd_val = {16'h0000, engine_route};
            mir_pkg::CSQ_STATUS: rd_val = {24'h000000, csq_half,
                CSQ_ENTRY[3].valid, CSQ_ENTRY[2].valid, CSQ_ENTRY[1].valid, CSQ_ENTRY[0].valid};
            default:
            begin
                if ((S_AXI_ARADDR & ~mir_pkg::RING_SPAN_MASK) == mir_pkg::RING_STATUS_BASE)
                begin
                    rd_val = RING_GROUP_DATA[ri];
                    // status read clears its rung bit
                    ring_clr[ri] = rd_go;
                end
                else if ((S_AXI_ARADDR & ~mir_pkg::CSQ_SPAN_MASK) == mir_pkg::CSQ_PORT_BASE)
                begin
                    // low word first, high word second
                    rd_val = csq_half[ci] ? CSQ_ENTRY[ci].data[63:32] :
                        CSQ_ENTRY[ci].data[31:0];
                    csq_sel[ci] = rd_go && CSQ_ENTRY[ci].valid;
                end
                else
                begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // entry leaves after its high word
    assign CSQ_POP = csq_sel & csq_half;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            csq_half <= '0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= mir_pkg::RESP_OKAY;
        end
        else
        begin
            csq_half <= csq_half ^ csq_sel;
            if (rd_go)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_val;
                S_AXI_RRESP <= rd_err ? mir_pkg::RESP_SLVERR : mir_pkg::RESP_OKAY;
            end
            else if (S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_rung_set;
        @(posedge MCLK) disable iff (RST)
        |RING_RUNG_SET |=> (rung & $past(RING_RUNG_SET)) == $past(RING_RUNG_SET);
    endproperty
    a_rung_set: assert property (p_rung_set) else $error("rung bit not set");

    property p_rung_hold;
        @(posedge MCLK) disable iff (RST)
        1'b1 |=> ((rung | $past(ring_clr)) & $past(rung)) == $past(rung);
    endproperty
    a_rung_hold: assert property (p_rung_hold) else $error("rung bit lost");

    property p_ring_host;
        @(posedge MCLK) disable iff (RST)
        (|RING_RUNG_SET && !ring_route) |=> HOST_INTR_VEC[mir_pkg::HV_RING];
    endproperty
    a_ring_host: assert property (p_ring_host) else $error("ring not sent to host");

    property p_slice;
        @(posedge MCLK) disable iff (RST)
        (rung[0] && ring_route && ring_map[3:0] != mir_pkg::FIELD_OFF)
        |=> LIC_VECTOR[$past(ring_map[3:0]) * mir_pkg::GROUP_VECS];
    endproperty
    a_slice: assert property (p_slice) else $error("ring not in its slice");

    property p_top;
        @(posedge MCLK) disable iff (RST)
        LIC_TOP_VALID |-> (LIC_VECTOR[LIC_TOP_GROUP * mir_pkg::GROUP_VECS +: 16] != 0)
            && ((LIC_VECTOR >> ((LIC_TOP_GROUP + 1) * mir_pkg::GROUP_VECS)) == 0);
    endproperty
    a_top: assert property (p_top) else $error("top group not highest");

    property p_engine_host;
        @(posedge MCLK) disable iff (RST)
        |(ENGINE_EVENT & ~engine_route) |=> HOST_INTR_VEC[mir_pkg::HV_ENGINE];
    endproperty
    a_engine_host: assert property (p_engine_host) else $error("engine not forwarded");

    property p_copy_done;
        @(posedge MCLK) disable iff (RST)
        COPY_DONE_EVENT |=> src_pending[mir_pkg::SP_DMA] ##1 1'b1;
    endproperty
    a_copy_done: assert property (p_copy_done) else $error("copy done lost");

    property p_host_trig;
        @(posedge MCLK) disable iff (RST)
        (host_trig && wreq.strb == 4'hF)
        |=> msg_data == $past(wreq.data) && src_pending[mir_pkg::SP_HOST];
    endproperty
    a_host_trig: assert property (p_host_trig) else $error("host message lost");

    property p_fw_owned;
        @(posedge MCLK) disable iff (RST)
        (fw_trig && !(|RING_RUNG_SET) && !(|ENGINE_EVENT) && HOST_VEC_ACK == 0)
        |=> HOST_INTR_VEC[7:0] == $past(HOST_INTR_VEC[7:0]);
    endproperty
    a_fw_owned: assert property (p_fw_owned) else $error("firmware hit hardware bit");

    property p_csq_pair;
        @(posedge MCLK) disable iff (RST)
        (csq_sel[0] && !csq_half[0]) |=> csq_half[0] && S_AXI_RDATA == $past(CSQ_ENTRY[0].data[31:0]);
    endproperty
    a_csq_pair: assert property (p_csq_pair) else $error("entry halves out of order");

    c_multi_rung: cover property (@(posedge MCLK) disable iff (RST) $countones(RING_RUNG_SET) > 1);
    c_fw_trig: cover property (@(posedge MCLK) disable iff (RST) fw_trig);
    c_csq_pop: cover property (@(posedge MCLK) disable iff (RST) |CSQ_POP);
endmodule // mir_router

// ===== bench/mir_fabric_model.sv
// fabric side model: ring registers and context status queues
`timescale 1ns/1ns
module mir_fabric_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] ring_req,
    input wire logic [3:0] pop,
    output logic [7:0] rung_set,
    output logic [7:0][31:0] group_data,
    output mir_pkg::mir_csq_t [3:0] csq
);
    logic [7:0] idle;
    logic [3:0] live;
    always_comb
        for (int g = 0; g < 8; g++) idle[g] = (group_data[g] == 32'h0);
    // first ring only, several groups in one message
    always_ff @(posedge clk or posedge rst)
        if (rst) rung_set <= 8'h00;
        else rung_set <= ring_req & idle;
    always_ff @(posedge clk or posedge rst)
        if (rst) group_data <= '0;
        else for (int g = 0; g < 8; g++) if (ring_req[g]) group_data[g][0] <= 1'b1;
    // head leaves on pop, queues hold one entry
    always_ff @(posedge clk or posedge rst)
        if (rst) live <= 4'hF;
        else live <= live & ~pop;
    always_comb
        for (int i = 0; i < 4; i++) csq[i] = {live[i], {64{~live[i]}} ^
            {28'h1000000, 4'(i), 28'h2000000, 4'(i)}};
endmodule // mir_fabric_model

// ===== bench/mir_router_tb_top.sv
// self-checking bench of the interrupt router
`timescale 1ns/1ns
module mir_router_tb_top;
    logic mclk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [4:0] src_ev;
    logic awready, wready, bvalid, arready, rvalid, top_valid;
    logic [15:0] awaddr, araddr, engine_event, host_ack, host_vec;
    logic [31:0] wdata, rdata, axi_rdata;
    logic [1:0] rresp, axi_rresp, bresp, wresp;
    logic [7:0] ring_req, rung_set;
    logic [3:0] pop, top_group;
    logic [7:0][31:0] group_data;
    logic [255:0] lic;
    mir_pkg::mir_csq_t [3:0] csq;
    int n_errors = 0;
    int cmp_count = 0;
    mir_router u_dut (.MCLK(mclk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(axi_rdata),
        .S_AXI_RRESP(axi_rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RING_RUNG_SET(rung_set), .RING_GROUP_DATA(group_data), .SEMAPHORE_EVENT(src_ev[1]),
        .ENGINE_EVENT(engine_event), .IOMMU_EVENT(src_ev[2]), .COPY_DONE_EVENT(src_ev[0]),
        .TIMER_EVENT(src_ev[3]), .FLR_EVENT(src_ev[4]), .CSQ_ENTRY(csq), .CSQ_POP(pop),
        .HOST_VEC_ACK(host_ack), .LIC_VECTOR(lic), .LIC_TOP_GROUP(top_group),
        .LIC_TOP_VALID(top_valid), .HOST_INTR_VEC(host_vec));
    mir_fabric_model u_fab (.clk(mclk), .rst(rst), .ring_req(ring_req), .pop(pop),
        .rung_set(rung_set), .group_data(group_data), .csq(csq));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        while (awvalid || wvalid)
        begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        @(negedge mclk);
        while (bvalid !== 1'b1) @(negedge mclk);
        wresp = bresp;
        @(posedge mclk);
        bready <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        @(negedge mclk);
        while (arready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        arvalid <= 1'b0;
        @(negedge mclk);
        while (rvalid !== 1'b1) @(negedge mclk);
        {rdata, rresp} = {axi_rdata, axi_rresp};
        @(posedge mclk);
        rready <= 1'b0;
        chk(n, rdata, e);
    endtask
    task automatic ev(input logic [7:0] r, input logic [15:0] e, input logic [4:0] c,
        input logic [15:0] k);
        @(posedge mclk);
        {ring_req, engine_event, src_ev, host_ack} <= {r, e, c, k};
        @(posedge mclk);
        {ring_req, engine_event, src_ev, host_ack} <= '0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic t_reset;
        rchk("ring_map", 16'hC500, 32'h0);
        rchk("notify_ctl", 16'hC508, 32'h0);
        chk("lic_any", {31'h0, |lic}, 32'h0);
        rchk("unmapped", 16'h0000, 32'h0);
        chk("rresp", {30'h0, rresp}, {30'h0, mir_pkg::RESP_SLVERR});
        wr(16'hC590, 32'h1);
        chk("wresp_ro", {30'h0, wresp}, {30'h0, mir_pkg::RESP_SLVERR});
    endtask
    task automatic t_ring_host;
        wr(16'hC500, 32'h09050500);
        chk("wresp_ok", {30'h0, wresp}, {30'h0, mir_pkg::RESP_OKAY});
        ev(8'h04, 16'h0, 1'b0, 16'h0);
        chk("host_ring", {31'h0, host_vec[0]}, 32'h1);
        chk("lic_s5", {16'h0, lic[95:80]}, 32'h0);
        rchk("rung", 16'hC508, 32'h4);
        rchk("ring2_stat", 16'hC528, 32'h1);
        rchk("rung_clr", 16'hC508, 32'h0);
    endtask
    task automatic t_ring_core;
        wr(16'hC508, 32'h100);
        ev(8'h50, 16'h0, 1'b0, 16'h0);
        rchk("rung2", 16'hC508, 32'h150);
        chk("lic_s5", {16'h0, lic[95:80]}, 32'h10);
        chk("lic_s9", {16'h0, lic[159:144]}, 32'h40);
        chk("top", {27'h0, top_valid, top_group}, 32'h19);
    endtask
    task automatic t_host;
        ev(8'h0, 16'h0, 1'b0, 16'hFFFF);
        wr(16'hC504, 32'h00030070);
        wr(16'hC514, 32'h1);
        wr(16'hC4C8, 32'hA5A50F0F);
        ev(8'h0, 16'h0003, 1'b1, 16'h0);
        rchk("msg", 16'hC590, 32'hA5A50F0F);
        rchk("pend", 16'hC50C, 32'h24);
        chk("lic_s3", {16'h0, lic[63:48]}, 32'h1);
        chk("lic_s7", {16'h0, lic[127:112]}, 32'h1);
        wr(16'hC4B8, 32'hFFFF);
        chk("host_vec", {16'h0, host_vec}, 32'hFF02);
    endtask
    task automatic t_misc;
        wr(16'hC504, 32'h00036472);
        ev(8'h0, 16'h0, 5'h1E, 16'h0);
        rchk("pend_all", 16'hC50C, 32'h3F);
        chk("lic_s2", {16'h0, lic[47:32]}, 32'h1);
        chk("lic_s4", {16'h0, lic[79:64]}, 32'h1);
        chk("lic_s6", {16'h0, lic[111:96]}, 32'h7);
    endtask
    task automatic t_csq;
        rchk("csq_lo", 16'hC540, 32'h20000000);
        rchk("csq_hi", 16'hC540, 32'h10000000);
        rchk("csq_stat", 16'hC518, 32'hE);
        for (int i = 1; i < 4; i++)
        begin
            rchk("csq_lo_n", 16'hC540 + 16'(4 * i), 32'h20000000 + i);
            rchk("csq_hi_n", 16'hC540 + 16'(4 * i), 32'h10000000 + i);
        end
        rchk("csq_empty", 16'hC518, 32'h0);
    endtask
    initial
    begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, ring_req, engine_event, host_ack, src_ev} = '0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_ring_host();
        t_ring_core();
        t_host();
        t_misc();
        t_csq();
        finish_test();
    end
    initial
    begin
        #40000;
        n_errors++;
        finish_test();
    end
endmodule // mir_router_tb_top
